// ==== verilog/dim_monitor.v ====
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dim_consts.vh"
module dim_monitor #(
  parameter FILT_CYC = `DIM_FILT_CYC,
  parameter DISC_CYC = `DIM_DISC_CYC
) (
  // clock and reset
  input  wire        mclk,
  input  wire        arst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // safety and limit inputs
  input  wire        safetyInputA,
  input  wire        safetyInputB,
  input  wire        forwardLimitInput,
  input  wire        reverseLimitInput,
  // drive side
  output reg         torqueEnable,
  output reg         safeStateIndication,
  output reg         stopMonitorOutput,
  output reg         safetyDisconnectAlarm,
  output reg         forwardAllow,
  output reg         reverseAllow,
  output reg         forwardOvertravel,
  output reg         reverseOvertravel,
  output reg  [1:0]  overtravelStopSelect,
  // interrupt
  output reg         irq
);

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  wire [3:0] cond;
  wire       inA;
  wire       inB;
  wire       fwdIn;
  wire       revIn;

  dim_in_cond #(
    .N    (4),
    .CW   (17),
    .FILT (FILT_CYC)
  ) uCond (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .rawIn     ({reverseLimitInput, forwardLimitInput, safetyInputB, safetyInputA}),
    .stableOut (cond)
  );

  assign inA   = cond[0];
  assign inB   = cond[1];
  assign fwdIn = cond[2];
  assign revIn = cond[3];

  // ----------------------------------------------------------------------
  // disagreement timer
  // ----------------------------------------------------------------------
  wire discExpired;

  dim_timer #(
    .CW    (30),
    .LIMIT (DISC_CYC)
  ) uDisc (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .run     (inA ^ inB),
    .expired (discExpired)
  );

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire access;
  wire wrEn;
  wire rdEn;
  wire hitCfg;
  wire hitCmd;
  wire hitStat;
  wire hitMask;
  wire hitLive;
  wire hitAny;

  // one wait state: pready rises in the second access cycle
  assign access  = psel & penable & pready;
  assign wrEn    = access & pwrite;
  assign rdEn    = access & ~pwrite;
  assign hitCfg  = (paddr == `DIM_OFF_CFG);
  assign hitCmd  = (paddr == `DIM_OFF_CMD);
  assign hitStat = (paddr == `DIM_OFF_STAT);
  assign hitMask = (paddr == `DIM_OFF_MASK);
  assign hitLive = (paddr == `DIM_OFF_LIVE);
  assign hitAny  = hitCfg | hitCmd | hitStat | hitMask | hitLive;

  // ----------------------------------------------------------------------
  // configuration: written copy and copy in effect
  // ----------------------------------------------------------------------
  reg [11:0] cfg_q;
  reg        fwdDis_q;
  reg        revDis_q;
  reg [7:0]  map_q;
  wire       restartCmd;
  wire       almClrCmd;

  assign restartCmd = wrEn & hitCmd & pwdata[`DIM_CMD_RESTART];
  assign almClrCmd  = wrEn & hitCmd & pwdata[`DIM_CMD_ALMCLR];

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= `DIM_CFG_RESET;
    end else if (wrEn & hitCfg) begin
      cfg_q <= pwdata[11:0];
    end
  end

  // settings take effect only at restart, which is accepted in any state, even with torque on
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fwdDis_q             <= 1'b0;
      revDis_q             <= 1'b0;
      overtravelStopSelect <= 2'h0;
      map_q                <= `DIM_MAP_RESET;
    end else if (restartCmd) begin
      fwdDis_q             <= cfg_q[`DIM_CFG_FWDDIS];
      revDis_q             <= cfg_q[`DIM_CFG_REVDIS];
      overtravelStopSelect <= cfg_q[`DIM_CFG_OTS_HI:`DIM_CFG_OTS_LO];
      map_q                <= cfg_q[`DIM_CFG_MAP_HI:`DIM_CFG_MAP_LO];
    end
  end

  // ----------------------------------------------------------------------
  // overtravel evaluation
  // ----------------------------------------------------------------------
  wire limitUsed;
  wire fwdHonour;
  wire revHonour;
  wire fwdOtNow;
  wire revOtNow;

  assign limitUsed = (map_q[3:0] == `DIM_CODE_FWD) | (map_q[7:4] == `DIM_CODE_FWD) |
                     (map_q[3:0] == `DIM_CODE_REV) | (map_q[7:4] == `DIM_CODE_REV);
  assign fwdHonour = limitUsed & ~fwdDis_q;
  assign revHonour = limitUsed & ~revDis_q;
  // each direction looks at its own switch only
  assign fwdOtNow  = fwdHonour & ~fwdIn;
  assign revOtNow  = revHonour & ~revIn;

  // ----------------------------------------------------------------------
  // safe state and alarm
  // ----------------------------------------------------------------------
  wire bothOn;
  wire bothOff;
  wire safeNow;

  assign bothOn  = inA & inB;
  assign bothOff = ~inA & ~inB;
  // one input off already drops torque; waiting for both would hide a broken channel
  assign safeNow = ~bothOn;

  // ----------------------------------------------------------------------
  // channel state, one-hot: both on, channels disagree, both off
  // ----------------------------------------------------------------------
  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_SPLIT = 3'b010;
  localparam [2:0] ST_SAFE  = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;

  // every state is left on the filtered levels alone, so a stuck channel
  // can never hold the drive in the operating state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (bothOff) begin
          state_d = ST_SAFE;
        end else if (safeNow) begin
          state_d = ST_SPLIT;
        end
      end
      ST_SPLIT: begin
        if (bothOn) begin
          state_d = ST_RUN;
        end else if (bothOff) begin
          state_d = ST_SAFE;
        end
      end
      ST_SAFE: begin
        // torque returns only with both channels on
        if (bothOn) begin
          state_d = ST_RUN;
        end else if (!bothOff) begin
          state_d = ST_SPLIT;
        end
      end
      default: begin
        state_d = ST_SAFE;
      end
    endcase
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_SAFE;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      torqueEnable        <= 1'b0;
      safeStateIndication <= 1'b1;
      stopMonitorOutput   <= 1'b0;
      forwardAllow        <= 1'b0;
      reverseAllow        <= 1'b0;
      forwardOvertravel   <= 1'b0;
      reverseOvertravel   <= 1'b0;
    end else begin
      torqueEnable        <= (state_d == ST_RUN);
      safeStateIndication <= (state_d != ST_RUN);
      stopMonitorOutput   <= (state_d == ST_SAFE);
      forwardAllow        <= ~fwdOtNow;
      reverseAllow        <= ~revOtNow;
      forwardOvertravel   <= fwdOtNow;
      reverseOvertravel   <= revOtNow;
    end
  end

  // alarm is latched; clearing is only honoured with both channels healthy
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      safetyDisconnectAlarm <= 1'b0;
    end else if (discExpired) begin
      safetyDisconnectAlarm <= 1'b1;
    end else if (almClrCmd & bothOn) begin
      safetyDisconnectAlarm <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // events, sticky status, interrupt
  // ----------------------------------------------------------------------
  wire [`DIM_EV_W-1:0] stat_q;
  reg  [`DIM_EV_W-1:0] mask_q;
  wire [`DIM_EV_W-1:0] evNow;

  assign evNow[`DIM_EV_SAFEIN]  = (state_q == ST_RUN) & (state_d != ST_RUN);
  assign evNow[`DIM_EV_SAFEOUT] = (state_q != ST_RUN) & (state_d == ST_RUN);
  assign evNow[`DIM_EV_ALARM]   = discExpired & ~safetyDisconnectAlarm;
  assign evNow[`DIM_EV_FWDOT]   = fwdOtNow & ~forwardOvertravel;
  assign evNow[`DIM_EV_REVOT]   = revOtNow & ~reverseOvertravel;

  // a new event in the clearing read wins; only bits that were read are cleared,
  // so an event landing between data capture and the clear is not lost
  genvar e;
  generate
    for (e = 0; e < `DIM_EV_W; e = e + 1) begin : gStat
      reg sticky_q;
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          sticky_q <= 1'b0;
        end else if (evNow[e]) begin
          sticky_q <= 1'b1;
        end else if (rdEn & hitStat & prdata[e]) begin
          sticky_q <= 1'b0;
        end
      end
      assign stat_q[e] = sticky_q;
    end
  endgenerate

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= {`DIM_EV_W{1'b0}};
    end else if (wrEn & hitMask) begin
      mask_q <= pwdata[`DIM_EV_W-1:0];
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------------
  reg [31:0] rdMux;

  always @* begin
    rdMux = 32'h0000_0000;
    if (hitCfg) begin
      rdMux[11:0] = cfg_q;
    end else if (hitStat) begin
      rdMux[`DIM_EV_W-1:0] = stat_q;
    end else if (hitMask) begin
      rdMux[`DIM_EV_W-1:0] = mask_q;
    end else if (hitLive) begin
      rdMux[0]     = inA;
      rdMux[1]     = inB;
      rdMux[2]     = fwdIn;
      rdMux[3]     = revIn;
      rdMux[4]     = safeStateIndication;
      rdMux[5]     = stopMonitorOutput;
      rdMux[6]     = safetyDisconnectAlarm;
      rdMux[7]     = forwardOvertravel;
      rdMux[8]     = reverseOvertravel;
      rdMux[9]     = fwdDis_q;
      rdMux[10]    = revDis_q;
      rdMux[11]    = limitUsed;
      rdMux[13:12] = overtravelStopSelect;
      rdMux[21:14] = map_q;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel & penable & ~pready) begin
      pready  <= 1'b1;
      pslverr <= ~hitAny;
      prdata  <= pwrite ? 32'h0000_0000 : rdMux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

endmodule // dim_monitor
`default_nettype wire

// ==== common/dim_consts.vh ====
// Function
// - Either or both safety inputs off: enter safe state, cut motor current, show indication.
// - Both safety inputs off: assert stop monitor output and enter safe state.
// - Both safety inputs back on: leave safe state, enter operating state.
// - One safety input off is enough for safe state, other may stay on.
// - Inputs disagreeing longer than ten seconds raise the disconnect alarm.
// - Forward limit on permits forward motion; off prohibits it and reports overtravel.
// - Reverse limit on permits reverse motion; off prohibits it and reports overtravel.
// - Forward limit disable: 0 honours input, 1 ignores it; applied at restart.
// - Reverse limit disable: 0 honours input, 1 ignores it; applied at restart.
// - Overtravel limiting off when no input carries function code 1 or 2.
// - Stop monitor output asserts within 5 ms of both safety inputs off.
// - Motor current cut within 5 ms of safety inputs turning off.
// - Safe-state and alarm reset only accepted while both safety inputs are on.
// - Off pulses under 1 ms ignored; safety controller keeps them shorter.
`ifndef DIM_CONSTS_VH
`define DIM_CONSTS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DIM_CLK_HZ        100000000
`define DIM_FILT_US       1000
`define DIM_FILT_CYC      ((`DIM_CLK_HZ / 1000000) * `DIM_FILT_US)
`define DIM_DISC_S        10
`define DIM_DISC_CYC      (`DIM_CLK_HZ * `DIM_DISC_S)

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define DIM_OFF_CFG       12'h000
`define DIM_OFF_CMD       12'h004
`define DIM_OFF_STAT      12'h008
`define DIM_OFF_MASK      12'h00C
`define DIM_OFF_LIVE      12'h010

// ----------------------------------------------------------------------
// config fields
// ----------------------------------------------------------------------
`define DIM_CFG_FWDDIS    0
`define DIM_CFG_REVDIS    1
`define DIM_CFG_OTS_LO    2
`define DIM_CFG_OTS_HI    3
`define DIM_CFG_MAP_LO    4
`define DIM_CFG_MAP_HI    11
`define DIM_CFG_RESET     12'h210
`define DIM_CODE_FWD      4'h1
`define DIM_CODE_REV      4'h2
`define DIM_MAP_RESET     8'h21

// ----------------------------------------------------------------------
// command bits
// ----------------------------------------------------------------------
`define DIM_CMD_RESTART   0
`define DIM_CMD_ALMCLR    1

// ----------------------------------------------------------------------
// event bits (status and mask share layout)
// ----------------------------------------------------------------------
`define DIM_EV_SAFEIN     0
`define DIM_EV_SAFEOUT    1
`define DIM_EV_ALARM      2
`define DIM_EV_FWDOT      3
`define DIM_EV_REVOT      4
`define DIM_EV_W          5

`endif

// ==== verilog/dim_in_cond.v ====
`timescale 1ns/1ps
`default_nettype none
module dim_in_cond #(
  parameter N    = 4,
  parameter CW   = 17,
  parameter FILT = 100000
) (
  // clock and reset
  input  wire          mclk,
  input  wire          arst_n,
  // raw and conditioned levels
  input  wire [N-1:0]  rawIn,
  output wire [N-1:0]  stableOut
);

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gBit
      reg          meta_q;
      reg          sync_q;
      reg          stable_q;
      reg [CW-1:0] cnt_q;
      // meta_q is read by sync_q only
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          meta_q   <= 1'b0;
          sync_q   <= 1'b0;
          stable_q <= 1'b0;
          cnt_q    <= {CW{1'b0}};
        end else begin
          meta_q <= rawIn[g];
          sync_q <= meta_q;
          // a level is believed only after it held for FILT cycles
          if (sync_q == stable_q) begin
            cnt_q <= {CW{1'b0}};
          end else if (cnt_q >= FILT[CW-1:0] - 1'b1) begin
            stable_q <= sync_q;
            cnt_q    <= {CW{1'b0}};
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end
      assign stableOut[g] = stable_q;
    end
  endgenerate

endmodule // dim_in_cond
`default_nettype wire

// ==== verilog/dim_timer.v ====
`timescale 1ns/1ps
`default_nettype none
module dim_timer #(
  parameter CW    = 30,
  parameter LIMIT = 1000000000
) (
  // clock and reset
  input  wire mclk,
  input  wire arst_n,
  // run level and expiry
  input  wire run,
  output reg  expired
);

  reg [CW-1:0] cnt_q;

  // counts while run holds; any drop restarts the wait
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q   <= {CW{1'b0}};
      expired <= 1'b0;
    end else if (!run) begin
      cnt_q   <= {CW{1'b0}};
      expired <= 1'b0;
    end else if (cnt_q >= LIMIT[CW-1:0]) begin
      expired <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // dim_timer
`default_nettype wire

// ==== test/dim_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module dim_checker #(
  parameter int FILT_CYC = 8,
  parameter int DISC_CYC = 50
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // safety inputs
  input wire logic safetyInputA,
  input wire logic safetyInputB,
  // drive side
  input wire logic torqueEnable,
  input wire logic safeStateIndication,
  input wire logic stopMonitorOutput,
  input wire logic safetyDisconnectAlarm,
  input wire logic forwardAllow,
  input wire logic reverseAllow,
  input wire logic forwardOvertravel,
  input wire logic reverseOvertravel
);
  // sync, filter and output stage, plus margin for the +-1 of the filter
  localparam int LAT = FILT_CYC + 6;
  logic [7:0] offCnt_q, anyCnt_q, onCnt_q, disCnt_q;
  // ------------------------------------------------------------------
  // raw run lengths, saturating so a long hold keeps its antecedent true
  // ------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      offCnt_q <= 8'h00;
      anyCnt_q <= 8'h00;
      onCnt_q  <= 8'h00;
      disCnt_q <= 8'h00;
    end else begin
      offCnt_q <= (!safetyInputA && !safetyInputB) ? offCnt_q + {7'h00, ~&offCnt_q} : 8'h00;
      anyCnt_q <= !(safetyInputA && safetyInputB) ? anyCnt_q + {7'h00, ~&anyCnt_q} : 8'h00;
      onCnt_q  <= (safetyInputA && safetyInputB) ? onCnt_q + {7'h00, ~&onCnt_q} : 8'h00;
      disCnt_q <= (safetyInputA ^ safetyInputB) ? disCnt_q + {7'h00, ~&disCnt_q} : 8'h00;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  safe_mirror_a:
    assert property (anyCnt_q >= LAT |-> safeStateIndication) else $error("safe state not shown");
  stop_needs_safe_a:
    assert property (stopMonitorOutput |-> safeStateIndication) else $error("stop outside safe");
  stop_latency_a:
    assert property (offCnt_q >= LAT |-> stopMonitorOutput) else $error("stop monitor late");
  one_off_safe_a:
    assert property (anyCnt_q >= LAT |-> !torqueEnable) else $error("torque kept on");
  both_on_run_a:
    assert property (onCnt_q >= LAT |-> torqueEnable && !stopMonitorOutput && !safeStateIndication)
      else $error("operating state not entered");
  pulse_ignore_a:
    assert property ($fell(torqueEnable) |-> anyCnt_q >= FILT_CYC) else $error("short dip taken");
  alarm_late_a:
    assert property ($rose(safetyDisconnectAlarm) |-> disCnt_q >= DISC_CYC)
      else $error("alarm too early");
  alarm_clear_a:
    assert property ($fell(safetyDisconnectAlarm) |-> onCnt_q >= FILT_CYC)
      else $error("alarm cleared with input off");
  fwd_ot_block_a:
    assert property (forwardOvertravel |-> !forwardAllow) else $error("forward not blocked");
  rev_ot_block_a:
    assert property (reverseOvertravel |-> !reverseAllow) else $error("reverse not blocked");
endmodule // dim_checker

bind dim_monitor dim_checker #(.FILT_CYC(FILT_CYC), .DISC_CYC(DISC_CYC)) u_dim_checker (
  .mclk(mclk), .arst_n(arst_n), .safetyInputA(safetyInputA), .safetyInputB(safetyInputB),
  .torqueEnable(torqueEnable), .safeStateIndication(safeStateIndication),
  .stopMonitorOutput(stopMonitorOutput), .safetyDisconnectAlarm(safetyDisconnectAlarm),
  .forwardAllow(forwardAllow), .reverseAllow(reverseAllow),
  .forwardOvertravel(forwardOvertravel), .reverseOvertravel(reverseOvertravel)
);
`default_nettype wire

// ==== test/dim_field_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dim_field_model #(
  parameter int PULSE_LEN = 4
) (
  // clock
  input  wire logic mclk,
  // commanded contact states
  input  wire logic wantA,
  input  wire logic wantB,
  input  wire logic wantFwd,
  input  wire logic wantRev,
  input  wire logic testPulse,
  // field wiring
  output logic      lineA,
  output logic      lineB,
  output logic      lineFwd,
  output logic      lineRev
);
  logic [3:0] pulseCnt_q = 4'h0;
  // self-test dip kept shorter than the input filter
  always @(posedge mclk) begin
    if (testPulse)
      pulseCnt_q <= 4'(PULSE_LEN);
    else if (pulseCnt_q != 4'h0)
      pulseCnt_q <= pulseCnt_q - 4'h1;
  end
  // normally closed contacts: an open contact reads low, never floats
  assign lineA   = wantA && (pulseCnt_q == 4'h0);
  assign lineB   = wantB;
  assign lineFwd = wantFwd;
  assign lineRev = wantRev;
endmodule // dim_field_model
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, rdErr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic        wantA, wantB, wantFwd, wantRev, testPulse, lineA, lineB, lineFwd, lineRev;
  logic        torqueOn, safeInd, stopMon, discAlm, fwdAllow, revAllow, fwdOt, revOt;
  logic [1:0]  otStop;
  integer      err_count, tests_run;
  dim_monitor #(.FILT_CYC(8), .DISC_CYC(50)) u_dim_monitor (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .safetyInputA(lineA), .safetyInputB(lineB), .forwardLimitInput(lineFwd),
    .reverseLimitInput(lineRev), .torqueEnable(torqueOn), .safeStateIndication(safeInd),
    .stopMonitorOutput(stopMon), .safetyDisconnectAlarm(discAlm), .forwardAllow(fwdAllow),
    .reverseAllow(revAllow), .forwardOvertravel(fwdOt), .reverseOvertravel(revOt),
    .overtravelStopSelect(otStop), .irq(irq)
  );
  dim_field_model u_dim_field_model (
    .mclk(mclk), .wantA(wantA), .wantB(wantB), .wantFwd(wantFwd), .wantRev(wantRev),
    .testPulse(testPulse), .lineA(lineA), .lineB(lineB), .lineFwd(lineFwd), .lineRev(lineRev)
  );
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 40) begin
      chk(pready, 1'h1);
      complete_run();
    end
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    apb(1'h0, 12'h000, 32'h0);
    chk(rdData, 32'h210);
    apb(1'h0, 12'h100, 32'h0);
    chk({31'h0, rdErr}, 32'h1);
    chk(rdData, 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk({31'h0, rdErr}, 32'h0);
    chk(rdData, 32'h0);
    // all four inputs on, limits in use with the reset map
    apb(1'h0, 12'h010, 32'h0);
    chk(rdData, 32'h0008480F);
    chk(torqueOn, 1'h1);
    $display("test t_regs done");
  endtask
  task automatic t_safe;
    apb(1'h0, 12'h008, 32'h0);
    apb(1'h1, 12'h00C, 32'h1);
    wantA <= 1'h0;
    cyc(16);
    chk({torqueOn, safeInd, stopMon, irq}, 4'h5);
    wantB <= 1'h0;
    cyc(16);
    chk({torqueOn, safeInd, stopMon}, 3'h3);
    wantA <= 1'h1;
    wantB <= 1'h1;
    cyc(16);
    chk({torqueOn, safeInd, stopMon}, 3'h4);
    apb(1'h0, 12'h008, 32'h0);
    chk(rdData, 32'h3);
    cyc(2);
    chk(irq, 1'h0);
    testPulse <= 1'h1;
    @(posedge mclk);
    testPulse <= 1'h0;
    cyc(16);
    chk({torqueOn, safeInd}, 2'h2);
    // a dip that was taken would have left a safe-state event behind
    apb(1'h0, 12'h008, 32'h0);
    chk(rdData, 32'h0);
    apb(1'h1, 12'h00C, 32'h0);
    $display("test t_safe done");
  endtask
  task automatic t_alarm;
    wantA <= 1'h0;
    cyc(90);
    chk(discAlm, 1'h1);
    // both off: the disagreement is gone, yet the clear must still be refused
    wantB <= 1'h0;
    cyc(16);
    apb(1'h1, 12'h004, 32'h2);
    cyc(3);
    chk(discAlm, 1'h1);
    wantA <= 1'h1;
    wantB <= 1'h1;
    cyc(16);
    chk(torqueOn, 1'h1);
    apb(1'h1, 12'h004, 32'h2);
    cyc(3);
    chk(discAlm, 1'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk(rdData, 32'h7);
    $display("test t_alarm done");
  endtask
  task automatic t_limits;
    wantFwd <= 1'h0;
    cyc(16);
    chk({fwdAllow, fwdOt, revAllow, revOt}, 4'h6);
    wantFwd <= 1'h1;
    wantRev <= 1'h0;
    cyc(16);
    chk({fwdAllow, fwdOt, revAllow, revOt}, 4'h9);
    chk(irq, 1'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk(rdData, 32'h18);
    apb(1'h1, 12'h000, 32'h211);
    wantFwd <= 1'h0;
    cyc(16);
    chk(fwdAllow, 1'h0);
    apb(1'h1, 12'h004, 32'h1);
    cyc(3);
    chk({fwdAllow, revAllow}, 2'h2);
    apb(1'h1, 12'h000, 32'h212);
    apb(1'h1, 12'h004, 32'h1);
    cyc(3);
    chk({fwdAllow, revAllow}, 2'h1);
    // stop option 2 as a vertical axis would use it
    apb(1'h1, 12'h000, 32'h338);
    apb(1'h1, 12'h004, 32'h1);
    cyc(3);
    chk({fwdAllow, revAllow, otStop}, 4'hE);
    apb(1'h0, 12'h000, 32'h0);
    chk(rdData, 32'h338);
    $display("test t_limits done");
  endtask
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    chk(1'h0, 1'h1);
    complete_run();
  end
  initial begin
    err_count = 0;
    tests_run = 0;
    arst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wantA = 1'h1;
    wantB = 1'h1;
    wantFwd = 1'h1;
    wantRev = 1'h1;
    testPulse = 1'h0;
    cyc(20);
    arst_n <= 1'h1;
    cyc(16);
    t_regs();
    t_safe();
    t_alarm();
    t_limits();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
